// *** hw/rlf_pkg.sv ***
// Shared constants and carrier types for the receive label filter block
package rlf_pkg;

	// ****************************************
	// Memory map
	// ****************************************
	localparam logic [15:0] RLF_RAM_LAST = 16'h3fff;
	localparam logic [15:0] RLF_EN_BASE = 16'h6800;
	localparam logic [15:0] RLF_EN_LAST = 16'h69ff;
	localparam logic [15:0] RLF_FIFO_BASE = 16'h7000;
	localparam logic [15:0] RLF_FIFO_LAST = 16'h707f;
	localparam logic [15:0] RLF_SYS_BASE = 16'h8000;
	localparam logic [15:0] RLF_SYS_LAST = 16'h80ff;
	localparam logic [15:0] RLF_CTRL_ADDR = 16'h8000;
	localparam logic [15:0] RLF_STAT_ADDR = 16'h8002;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int RLF_READY_BIT = 5;
	localparam int RLF_FAULT_BIT = 3;
	localparam int RLF_WRAP_BIT = 0;
	localparam int RLF_FIFO_BIT = 1;
	localparam logic [7:0] RLF_CTRL_RST = 8'h00;
	localparam logic [7:0] RLF_EE_BLANK = 8'hff;
	localparam logic [2:0] RLF_FIFO_POP_BYTE = 3'h3;
	localparam logic [2:0] RLF_FIFO_CNT_BYTE = 3'h4;

	// ****************************************
	// Sizes, modes and counts
	// ****************************************
	localparam int RLF_CH = 16;
	localparam int RLF_FIFO_DEPTH = 64;
	localparam int RLF_RAM_WORDS = 4096;
	localparam logic [2:0] RLF_MODE_AUTO1 = 3'h1;
	localparam logic [2:0] RLF_MODE_AUTO3 = 3'h3;
	localparam logic [1:0] RLF_SYNC_CYC = 2'h2;

	typedef enum logic [2:0] {
		RLF_ST_LATCH = 3'b000,
		RLF_ST_REQ = 3'b001,
		RLF_ST_WAIT = 3'b010,
		RLF_ST_READY = 3'b011,
		RLF_ST_FAULT = 3'b100
	} rlf_state_t;

	typedef struct packed {
		logic valid;
		logic [3:0] ch;
		logic [31:0] data;
	} rlf_word_t;

	typedef struct packed {
		logic valid;
		logic [2:0] ch;
		logic [31:0] data;
	} rlf_txw_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rlf_host_t;

endpackage

// *** hw/rlf_top.sv ***
// Receive label filter, storage and auto-initialisation engine
`timescale 1ns/10ps
module rlf_top import rlf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_mode,
	input wire rlf_word_t i_rx,
	input wire rlf_txw_t i_tx,
	input wire rlf_host_t i_host,
	input wire logic i_ee_valid,
	input wire logic [7:0] i_ee_data,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_ready,
	output logic o_fault,
	output logic o_ee_rd,
	output logic [15:0] o_ee_addr
);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ****************************************
	// Mode pins and start-up sequencer
	// ****************************************
	logic [2:0] mode_s1_q, mode_s2_q;
	rlf_state_t st_q, st_d;
	logic [1:0] dly_q, dly_d;
	logic [15:0] addr_q, addr_d;
	logic blank_q, blank_d;
	logic ee_rd_d, ready_d, fault_d;
	logic auto_mode;
	logic copy_wr;

	assign auto_mode = (mode_s2_q == RLF_MODE_AUTO1) || (mode_s2_q == RLF_MODE_AUTO3);
	assign copy_wr = (st_q == RLF_ST_WAIT) && i_ee_valid;

	always_comb begin
		st_d = st_q;
		dly_d = dly_q;
		addr_d = addr_q;
		blank_d = blank_q;
		ee_rd_d = 1'b0;
		case (st_q)
			RLF_ST_LATCH: begin
				dly_d = dly_q + 2'h1;
				blank_d = 1'b1;
				if (dly_q == RLF_SYNC_CYC) begin
					dly_d = dly_q;
					addr_d = RLF_EN_BASE;
					st_d = auto_mode ? RLF_ST_REQ : RLF_ST_READY;
				end
			end
			RLF_ST_REQ: begin
				ee_rd_d = 1'b1;
				st_d = RLF_ST_WAIT;
			end
			RLF_ST_WAIT: begin
				ee_rd_d = 1'b1;
				if (i_ee_valid) begin
					ee_rd_d = 1'b0;
					blank_d = blank_q && (i_ee_data == RLF_EE_BLANK);
					st_d = RLF_ST_REQ;
					// Table first, then the whole register page
					if (addr_q == RLF_EN_LAST) begin
						addr_d = RLF_SYS_BASE;
					end else if (addr_q == RLF_SYS_LAST) begin
						st_d = blank_d ? RLF_ST_FAULT : RLF_ST_READY;
					end else begin
						addr_d = addr_q + 16'h0001;
					end
				end
			end
			RLF_ST_READY: begin
				st_d = RLF_ST_READY;
			end
			RLF_ST_FAULT: begin
				st_d = RLF_ST_FAULT;
			end
			default: begin
				st_d = RLF_ST_LATCH;
			end
		endcase
		ready_d = (st_d == RLF_ST_READY);
		fault_d = (st_d == RLF_ST_FAULT);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_s1_q <= 3'h0;
			mode_s2_q <= 3'h0;
			st_q <= RLF_ST_LATCH;
			dly_q <= 2'h0;
			addr_q <= 16'h0000;
			blank_q <= 1'b1;
			o_ee_rd <= 1'b0;
			o_ee_addr <= 16'h0000;
			o_ready <= 1'b0;
			o_fault <= 1'b0;
		end else begin
			mode_s1_q <= i_mode;
			mode_s2_q <= mode_s1_q;
			st_q <= st_d;
			dly_q <= dly_d;
			addr_q <= addr_d;
			blank_q <= blank_d;
			o_ee_rd <= ee_rd_d;
			o_ee_addr <= addr_d;
			o_ready <= ready_d;
			o_fault <= fault_d;
		end
	end

	// ****************************************
	// Shared write port: EEPROM copy or host
	// ****************************************
	// Host writes are refused until ready, so a copy is never disturbed
	logic w_en;
	logic [15:0] w_addr;
	logic [7:0] w_data;
	logic [7:0] ctrl_q, ctrl_d;
	logic wrap_mode, fifo_mode;

	always_comb begin
		w_en = copy_wr || (o_ready && i_host.wr);
		w_addr = copy_wr ? addr_q : i_host.addr;
		w_data = copy_wr ? i_ee_data : i_host.wdata;
		ctrl_d = ctrl_q;
		if (w_en && (w_addr == RLF_CTRL_ADDR)) begin
			ctrl_d = w_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_q <= RLF_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign wrap_mode = ctrl_q[RLF_WRAP_BIT];
	assign fifo_mode = ctrl_q[RLF_FIFO_BIT];

	// ****************************************
	// Label enable table
	// ****************************************
	logic [255:0] en_q [RLF_CH];
	logic en_hit;
	logic [3:0] en_ch;
	logic [7:0] en_bit;

	assign en_hit = (w_addr >= RLF_EN_BASE) && (w_addr <= RLF_EN_LAST);
	assign en_ch = w_addr[8:5];
	assign en_bit = {w_addr[4:0], 3'b000};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int c = 0; c < RLF_CH; c++) begin
				en_q[c] <= '0;
			end
		end else if (w_en && en_hit) begin
			en_q[en_ch][en_bit +: 8] <= w_data;
		end
	end

	// ****************************************
	// Receive events and filter
	// ****************************************
	rlf_word_t ev0, ev1;
	logic acc0, acc1;
	logic [11:0] ridx0, ridx1;

	always_comb begin
		ev0 = i_rx;
		ev1 = '0;
		if (wrap_mode) begin
			// External receivers are ignored while wrapped
			ev0 = {i_tx.valid, i_tx.ch, 1'b0, i_tx.data};
			ev1 = {i_tx.valid, i_tx.ch, 1'b1, i_tx.data};
		end
	end

	assign acc0 = o_ready && ev0.valid && en_q[ev0.ch][ev0.data[7:0]];
	assign acc1 = o_ready && ev1.valid && en_q[ev1.ch][ev1.data[7:0]];
	assign ridx0 = {ev0.ch, ev0.data[7:0]};
	assign ridx1 = {ev1.ch, ev1.data[7:0]};

	// ****************************************
	// Label-indexed RAM buffers
	// ****************************************
	logic [31:0] ram_q [RLF_RAM_WORDS];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < RLF_RAM_WORDS; i++) begin
				ram_q[i] <= 32'h0000_0000;
			end
		end else begin
			// The two wrapped events always hit different channels
			if (acc0 && !fifo_mode) begin
				ram_q[ridx0] <= ev0.data;
			end
			if (acc1 && !fifo_mode) begin
				ram_q[ridx1] <= ev1.data;
			end
		end
	end

	// ****************************************
	// Per-channel receive queues
	// ****************************************
	// A full queue drops the newest word so unread messages survive
	logic [31:0] head [RLF_CH];
	logic [6:0] count [RLF_CH];
	logic fifo_rd;
	logic [3:0] fifo_ch;
	logic pop_req;

	assign fifo_rd = (i_host.addr >= RLF_FIFO_BASE) && (i_host.addr <= RLF_FIFO_LAST);
	assign fifo_ch = i_host.addr[6:3];
	assign pop_req = o_ready && i_host.rd && fifo_rd && (i_host.addr[2:0] == RLF_FIFO_POP_BYTE);

	for (genvar c = 0; c < RLF_CH; c++) begin : g_fifo
		logic [31:0] mem_q [RLF_FIFO_DEPTH];
		logic [5:0] wp_q, rp_q;
		logic [6:0] cnt_q;
		logic hit0, hit1, push, pop;
		logic [31:0] pw;

		assign hit0 = acc0 && (ev0.ch == 4'(c));
		assign hit1 = acc1 && (ev1.ch == 4'(c));
		assign push = fifo_mode && (hit0 || hit1) && (cnt_q != 7'(RLF_FIFO_DEPTH));
		assign pop = pop_req && (fifo_ch == 4'(c)) && (cnt_q != 7'h00);
		assign pw = hit0 ? ev0.data : ev1.data;
		assign head[c] = mem_q[rp_q];
		assign count[c] = cnt_q;

		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				wp_q <= 6'h00;
				rp_q <= 6'h00;
				cnt_q <= 7'h00;
				for (int i = 0; i < RLF_FIFO_DEPTH; i++) begin
					mem_q[i] <= 32'h0000_0000;
				end
			end else begin
				if (push) begin
					mem_q[wp_q] <= pw;
					wp_q <= wp_q + 6'h01;
				end
				if (pop) begin
					rp_q <= rp_q + 6'h01;
				end
				if (push && !pop) begin
					cnt_q <= cnt_q + 7'h01;
				end else if (pop && !push) begin
					cnt_q <= cnt_q - 7'h01;
				end
			end
		end
	end

	// ****************************************
	// Host read port
	// ****************************************
	logic [7:0] rd_d, stat;
	logic [31:0] rword;

	always_comb begin
		stat = 8'h00;
		stat[RLF_READY_BIT] = o_ready;
		stat[RLF_FAULT_BIT] = o_fault;
		rd_d = 8'h00;
		rword = 32'h0000_0000;
		if (i_host.addr <= RLF_RAM_LAST) begin
			// Channel in the top four index bits, label below
			rword = ram_q[i_host.addr[13:2]];
			rd_d = rword[{i_host.addr[1:0], 3'b000} +: 8];
		end else if ((i_host.addr >= RLF_EN_BASE) && (i_host.addr <= RLF_EN_LAST)) begin
			rd_d = en_q[i_host.addr[8:5]][{i_host.addr[4:0], 3'b000} +: 8];
		end else if (fifo_rd) begin
			rword = head[fifo_ch];
			if (i_host.addr[2:0] == RLF_FIFO_CNT_BYTE) begin
				rd_d = {1'b0, count[fifo_ch]};
			end else if (i_host.addr[2] == 1'b0) begin
				rd_d = rword[{i_host.addr[1:0], 3'b000} +: 8];
			end
		end else if (i_host.addr == RLF_CTRL_ADDR) begin
			rd_d = ctrl_q;
		end else if (i_host.addr == RLF_STAT_ADDR) begin
			rd_d = stat;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_data <= i_host.rd ? rd_d : 8'h00;
			o_rd_valid <= i_host.rd;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_latch_done;
		(st_q == RLF_ST_LATCH) && (dly_q == RLF_SYNC_CYC);
	endsequence

	sequence s_copy_start;
		!o_ready ##1 (o_ee_rd && (o_ee_addr == RLF_EN_BASE));
	endsequence

	no_ee_ready_a: assert property (s_latch_done and !auto_mode |=> o_ready)
		else $error("ready not raised without eeprom");
	auto_copy_a: assert property (s_latch_done and auto_mode |=> s_copy_start)
		else $error("auto mode did not start copy at table base");
	copy_span_a: assert property (copy_wr && (addr_q == RLF_EN_LAST) |=>
		(addr_q == RLF_SYS_BASE) ##1 (o_ee_addr == RLF_SYS_BASE))
		else $error("copy did not move on to register page");
	blank_fault_a: assert property (copy_wr && (addr_q == RLF_SYS_LAST) && blank_q &&
		(i_ee_data == RLF_EE_BLANK) |=> o_fault && !o_ready)
		else $error("blank eeprom did not fault");
	status_read_a: assert property (i_host.rd && (i_host.addr == RLF_STAT_ADDR) |=>
		o_rd_valid && (o_rd_data[RLF_READY_BIT] == $past(o_ready)))
		else $error("status byte does not show readiness");
	status_ro_a: assert property (o_ready && i_host.wr && (i_host.addr == RLF_STAT_ADDR)
		|=> o_ready [*2])
		else $error("status write changed readiness");
	filter_drop_a: assert property (o_ready && ev0.valid && !acc0 && !fifo_mode &&
		!(acc1 && (ridx1 == ridx0)) |=> ram_q[$past(ridx0)] == $past(ram_q[ridx0]))
		else $error("disabled label reached ram");
	ram_store_a: assert property (acc0 && !fifo_mode |=>
		ram_q[$past(ridx0)] == $past(ev0.data))
		else $error("accepted word not stored in its buffer");
	wrap_twice_a: assert property (wrap_mode && i_tx.valid |-> ev1.valid &&
		(ev1.ch == {i_tx.ch, 1'b1}) && (ev0.ch == {i_tx.ch, 1'b0}) && (ev1.data == ev0.data))
		else $error("wrapped word not sent to two receivers");
	table_clear_a: assert property (@(posedge i_clk) $fell(i_rst) |->
		(en_q[0] == '0) && (en_q[15] == '0) && !o_ready)
		else $error("table not cleared by reset");

endmodule

// *** test/rlf_ee_model.sv ***
// Serial configuration memory model answering the copy sequencer
`timescale 1ns/10ps
module rlf_ee_model import rlf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_blank,
	input wire logic i_ee_rd,
	input wire logic [15:0] i_ee_addr,
	output logic o_ee_valid,
	output logic [7:0] o_ee_data
);
	logic [1:0] wait_q;
	// ****************************************
	// Answer path
	// ****************************************
	// Odd addresses answer three cycles late to exercise a slow memory
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ee_valid <= 1'b0;
			o_ee_data <= 8'h00;
			wait_q <= 2'h0;
		end else if (i_ee_rd && !o_ee_valid && wait_q == (i_ee_addr[0] ? 2'h3 : 2'h0)) begin
			o_ee_valid <= 1'b1;
			o_ee_data <= i_blank ? 8'hff : (i_ee_addr == 16'h6800 ? 8'h04 : 8'h00);
			wait_q <= 2'h0;
		end else begin
			// Data is meaningless outside a strobe, so it keeps moving
			o_ee_valid <= 1'b0;
			o_ee_data <= ~o_ee_data;
			if (i_ee_rd && !o_ee_valid) begin
				wait_q <= wait_q + 2'h1;
			end
		end
	end
endmodule

// *** test/rlf_top_tb.sv ***
// Self-checking testbench for the receive label filter block
`timescale 1ns/10ps
module rlf_top_tb import rlf_pkg::*;;
	logic i_clk, i_rst, blank, ee_valid, rd_valid, ready, fault, ee_rd;
	logic [2:0] mode;
	logic [7:0] ee_data, rd_data;
	logic [15:0] ee_addr;
	rlf_word_t rx;
	rlf_txw_t tx;
	rlf_host_t host;
	int err_count, checks_done, cyc, n;

	rlf_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_mode(mode), .i_rx(rx), .i_tx(tx),
		.i_host(host), .i_ee_valid(ee_valid), .i_ee_data(ee_data), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_ready(ready), .o_fault(fault), .o_ee_rd(ee_rd),
		.o_ee_addr(ee_addr));
	rlf_ee_model ee_u (.i_clk(i_clk), .i_rst(i_rst), .i_blank(blank), .i_ee_rd(ee_rd),
		.i_ee_addr(ee_addr), .o_ee_valid(ee_valid), .o_ee_data(ee_data));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic final_report();
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		host <= '0;
		#1;
		chk("rd_valid", {7'h00, rd_valid}, 8'h01);
		chk($sformatf("rd %h", a), rd_data, exp);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge i_clk);
		host <= '0;
	endtask
	task automatic send(input logic [3:0] ch, input logic [31:0] d);
		@(posedge i_clk);
		rx <= '{valid: 1'b1, ch: ch, data: d};
		@(posedge i_clk);
		rx <= '0;
	endtask
	// Holds reset 16 cycles, then counts edges until ready or fault
	task automatic do_reset(input logic [2:0] m);
		@(posedge i_clk);
		mode <= m;
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		n = 0;
		while (n < 6000 && ready !== 1'b1 && fault !== 1'b1) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// Full run needs about 7200 cycles, mostly two table copies
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			final_report();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_rst = 1'b1;
		mode = 3'h0;
		blank = 1'b0;
		rx = '0;
		tx = '0;
		host = '0;
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		// Two edges fill the mode synchroniser, readiness follows at the third
		do_reset(3'h2);
		chk("ready_edges", 8'(n), 8'h03);
		do_reset(3'h5);
		chk("ready_edges", 8'(n), 8'h03);
		do_reset(3'h0);
		chk("ready_edges", 8'(n), 8'h03);
		rd(RLF_STAT_ADDR, 8'h20);
		wr(RLF_STAT_ADDR, 8'h00);
		rd(RLF_STAT_ADDR, 8'h20);
		rd(RLF_CTRL_ADDR, 8'h00);
		rd(16'h69ff, 8'h00);
		wr(16'h69ff, 8'h80);
		rd(16'h69ff, 8'h80);
		send(4'hf, 32'h123456ff);
		rd(16'h3ffd, 8'h56);
		send(4'h3, 32'h00563402);
		rd(16'h0c08, 8'h00);
		wr(16'h6860, 8'h04);
		send(4'h3, 32'h00563402);
		rd(16'h0c08, 8'h02);
		rd(16'h0c0a, 8'h56);
		send(4'h3, 32'h00783a02);
		rd(16'h0c09, 8'h3a);
		send(4'h3, 32'h00000003);
		rd(16'h0c0c, 8'h00);
		// Wrap: transmitter 2 lands on receivers 4 and 5
		wr(16'h6880, 8'h04);
		wr(16'h68a0, 8'h04);
		wr(RLF_CTRL_ADDR, 8'h01);
		@(posedge i_clk);
		tx <= '{valid: 1'b1, ch: 3'h2, data: 32'h00563402};
		@(posedge i_clk);
		tx <= '0;
		rd(16'h1009, 8'h34);
		rd(16'h1409, 8'h34);
		// Queue mode: one more word than fits, newest dropped
		wr(RLF_CTRL_ADDR, 8'h02);
		repeat (65) send(4'h3, 32'h00563402);
		rd(16'h701c, 8'h40);
		rd(16'h7018, 8'h02);
		rd(16'h7019, 8'h34);
		rd(16'h701a, 8'h56);
		rd(16'h701b, 8'h00);
		rd(16'h701c, 8'h3f);
		do_reset(3'h1);
		chk("ready", {7'h00, ready}, 8'h01);
		chk("ee_rd_idle", {7'h00, ee_rd}, 8'h00);
		chk("ee_addr_hi", ee_addr[15:8], 8'h80);
		chk("ee_addr_lo", ee_addr[7:0], 8'hff);
		rd(16'h7018, 8'h00);
		rd(16'h6800, 8'h04);
		send(4'h0, 32'h00563402);
		rd(16'h0008, 8'h02);
		blank <= 1'b1;
		do_reset(3'h3);
		chk("fault", {7'h00, fault}, 8'h01);
		chk("ready", {7'h00, ready}, 8'h00);
		rd(RLF_STAT_ADDR, 8'h08);
		final_report();
	end
endmodule
